// ---- pot_cmd_pkg.sv ----
// Summary of operation
// R01 - Serial inputs ignored while nonvolatile write runs.
// R02 - Stop after nonvolatile command starts write cycle.
// R03 - Master polls with start and address until acknowledged.
// R04 - No address acknowledge while write busy.
// R05 - Instruction byte: opcode, then store select bits.
// R06 - Bit one zero; bit zero selects pot.
// R07 - Opcode 1001 reads wiper, store select zero.
// R08 - Opcode 1010 loads wiper from host byte.
// R09 - Opcode 1011 reads selected setting store.
// R10 - Opcode 1100 writes store, nonvolatile cycle.
// R11 - Opcode 1101 copies store to wiper, delayed.
// R12 - Opcode 1110 saves wiper into store, nonvolatile.
// R13 - Opcode 0001 global recall from stores.
// R14 - Opcode 1000 global save into stores.
// R15 - Opcode 0010 enables stepping until stop.
// R16 - Step clock with data high moves up.
// R17 - Step clock with data low moves down.
// R18 - Six-bit wiper decoded to one of sixty-four.
// R19 - Reset loads each wiper from store zero.
// R20 - Nonvolatile write finishes within ten milliseconds.
// R21 - Write protect low blocks nonvolatile writes.
// R22 - Acknowledge address, instruction and data byte.
// R23 - Respond only on type and strap match.
// R24 - Stepping saturates at both ends.
// R25 - Read byte: two zeros, then value.
package pot_cmd_pkg;
  localparam int WIPER_W = 6;
  localparam int SWITCHES = 64;
  localparam int NUM_POTS = 2;
  localparam int NUM_STORES = 8;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] OP_READ_WIPER = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
  localparam logic [3:0] OP_READ_STORE = 4'hb;
  localparam logic [3:0] OP_WRITE_STORE = 4'hc;
  localparam logic [3:0] OP_STORE_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_WIPER_TO_STORE = 4'he;
  localparam logic [3:0] OP_GLOBAL_RECALL = 4'h1;
  localparam logic [3:0] OP_GLOBAL_SAVE = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  // The value is arbitrary.
  localparam logic [3:0] DEVICE_TYPE_ID = 4'ha;
  localparam logic [5:0] WIPER_MAX = 6'h3f;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam logic [5:0] STORE_RESET = 6'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int NV_WRITE_TIME_MS = 5;
  localparam int NV_WRITE_MAX_MS = 10;
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * 1000 * 1000 / CLK_PERIOD_NS;
  localparam int NV_WRITE_MAX_CYCLES = NV_WRITE_MAX_MS * 1000 * 1000 / CLK_PERIOD_NS;
  localparam int WIPER_RESP_NS = 1000;
  localparam int WIPER_RESP_CYCLES = (WIPER_RESP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_INSTR, ST_DATA, ST_ACK, ST_READ, ST_MASTER_ACK, ST_STEP, ST_WAIT
  } state_type;
  typedef struct packed {
    logic [3:0] dev_type;
    logic [3:0] strap;
  } addr_type;
  typedef struct packed {
    logic [3:0] opcode;
    logic [1:0] sel;
    logic       rsvd;
    logic       pot;
  } instr_type;
  typedef struct packed {
    logic [1:0]              mask;
    logic [1:0]              sel;
    logic [1:0][WIPER_W-1:0] val;
  } nv_req_type;
endpackage

// ---- dual_pot_command_decoder.sv ----
module dual_pot_command_decoder #(
  parameter logic [3:0] DEVICE_TYPE_ID    = pot_cmd_pkg::DEVICE_TYPE_ID,
  parameter int         NV_WRITE_CYCLES   = pot_cmd_pkg::NV_WRITE_CYCLES,
  parameter int         WIPER_RESP_CYCLES = pot_cmd_pkg::WIPER_RESP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [3:0]  strap_addr,
  input  wire logic        write_protect_n,
  output logic             nv_busy,
  output logic [63:0]      wiper_switch0,
  output logic [63:0]      wiper_switch1
);
  localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);
  localparam int HOLD_W = $clog2(WIPER_RESP_CYCLES + 1);
  localparam int W = pot_cmd_pkg::WIPER_W;

  function automatic logic [2:0] idx(input logic pot, input logic [1:0] sel);
    return {pot, sel};
  endfunction

  function automatic logic [1:0] pot_mask(input logic pot);
    return pot ? 2'h2 : 2'h1;
  endfunction

  function automatic logic [W-1:0] step(input logic [W-1:0] w, input logic up);
    if (up) begin
      return (w == pot_cmd_pkg::WIPER_MAX) ? w : w + 6'h01;
    end
    return (w == pot_cmd_pkg::WIPER_MIN) ? w : w - 6'h01;
  endfunction

  function automatic logic [63:0] decode(input logic [W-1:0] w);
    return 64'h1 << w;
  endfunction

  logic                   scl_meta_ff;
  logic                   scl_ff;
  logic                   scl_prev_ff;
  logic                   sda_meta_ff;
  logic                   sda_ff;
  logic                   sda_prev_ff;
  logic [3:0]             strap_meta_ff;
  logic [3:0]             strap_ff;
  logic                   wp_meta_ff;
  logic                   wp_ff;
  pot_cmd_pkg::state_type state_ff;
  pot_cmd_pkg::state_type nxt_state;
  pot_cmd_pkg::state_type after_ack_ff;
  pot_cmd_pkg::state_type nxt_after;
  logic [3:0]             bit_cnt_ff;
  logic [3:0]             nxt_cnt;
  logic [7:0]             shift_ff;
  logic [7:0]             nxt_shift;
  logic [7:0]             tx_ff;
  logic [7:0]             nxt_tx;
  logic                   ack_on_ff;
  logic                   nxt_ack_on;
  logic                   sda_oe_n_ff;
  logic                   nxt_oe_n;
  pot_cmd_pkg::instr_type cmd_ff;
  pot_cmd_pkg::instr_type nxt_cmd;
  logic                   nv_pend_ff;
  logic                   nxt_pend;
  pot_cmd_pkg::nv_req_type nv_req_ff;
  pot_cmd_pkg::nv_req_type nxt_req;
  logic [W-1:0]           wiper_ff [pot_cmd_pkg::NUM_POTS];
  logic [W-1:0]           nxt_wiper [pot_cmd_pkg::NUM_POTS];
  logic [W-1:0]           store_ff [pot_cmd_pkg::NUM_STORES];
  logic                   recall_ff;
  logic                   copy_op;
  logic                   commit;
  logic [BUSY_W-1:0]      busy_cnt_ff;
  logic [BUSY_W-1:0]      nxt_busy_cnt;
  logic                   nv_busy_ff;
  logic [HOLD_W-1:0]      hold_cnt_ff;
  logic [63:0]            switch0_ff;
  logic [63:0]            switch1_ff;

  wire scl_rise = scl_ff & ~scl_prev_ff;
  wire scl_fall = ~scl_ff & scl_prev_ff;
  wire start_det = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
  wire stop_det = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;
  wire busy = busy_cnt_ff != '0;
  wire [7:0] rx_byte = {shift_ff[pot_cmd_pkg::BYTE_W-2:0], sda_ff};
  wire pot_cmd_pkg::addr_type rx_addr = pot_cmd_pkg::addr_type'(rx_byte);
  wire pot_cmd_pkg::instr_type rx_instr = pot_cmd_pkg::instr_type'(rx_byte);
  wire addr_ok = rx_addr.dev_type == DEVICE_TYPE_ID && rx_addr.strap == strap_ff; // R23
  wire rx_state = state_ff == pot_cmd_pkg::ST_ADDR || state_ff == pot_cmd_pkg::ST_INSTR ||
                  state_ff == pot_cmd_pkg::ST_DATA;
  wire byte_done = rx_state && scl_rise && bit_cnt_ff == pot_cmd_pkg::BYTE_LAST;
  wire sel_zero = rx_instr.sel == 2'h0;
  wire [W-1:0] sel_wiper = wiper_ff[cmd_ff.pot];
  wire [W-1:0] rx_wiper = rx_instr.pot ? wiper_ff[1] : wiper_ff[0];
  wire [W-1:0] rx_store = store_ff[idx(rx_instr.pot, rx_instr.sel)];

  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_ff;
  assign nv_busy = nv_busy_ff;
  assign wiper_switch0 = switch0_ff;
  assign wiper_switch1 = switch1_ff;

  always_ff @(posedge clk) begin
    scl_meta_ff <= scl_in;
    scl_ff <= scl_meta_ff;
    scl_prev_ff <= scl_ff;
    sda_meta_ff <= sda_in;
    sda_ff <= sda_meta_ff;
    sda_prev_ff <= sda_ff;
    strap_meta_ff <= strap_addr;
    strap_ff <= strap_meta_ff;
    wp_meta_ff <= write_protect_n;
    wp_ff <= wp_meta_ff;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_after = after_ack_ff;
    nxt_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_tx = tx_ff;
    nxt_ack_on = ack_on_ff;
    nxt_oe_n = sda_oe_n_ff;
    nxt_cmd = cmd_ff;
    nxt_pend = nv_pend_ff;
    nxt_req = nv_req_ff;
    nxt_wiper = wiper_ff;
    copy_op = 1'b0;
    commit = 1'b0;
    if (recall_ff) begin
      nxt_wiper[0] = store_ff[idx(1'b0, 2'h0)]; // R19
      nxt_wiper[1] = store_ff[idx(1'b1, 2'h0)]; // R19
    end else if (busy) begin
      // Bus activity is not seen, so a polled address is never acknowledged.
      nxt_state = pot_cmd_pkg::ST_IDLE; // R01 R04 R20
      nxt_oe_n = 1'b1; // R04
      nxt_ack_on = 1'b0;
    end else if (stop_det) begin
      nxt_state = pot_cmd_pkg::ST_IDLE;
      nxt_oe_n = 1'b1;
      nxt_ack_on = 1'b0;
      nxt_pend = 1'b0;
      commit = nv_pend_ff & wp_ff; // R02 R21
    end else if (start_det) begin
      nxt_state = pot_cmd_pkg::ST_ADDR;
      nxt_cnt = '0;
      nxt_oe_n = 1'b1;
      nxt_ack_on = 1'b0;
      nxt_pend = 1'b0;
    end else begin
      if (rx_state && scl_rise) begin
        nxt_shift = rx_byte;
        nxt_cnt = byte_done ? 4'h0 : bit_cnt_ff + 4'h1;
      end
      unique case (state_ff)
        pot_cmd_pkg::ST_IDLE, pot_cmd_pkg::ST_WAIT: begin
        end
        pot_cmd_pkg::ST_ADDR: begin
          if (byte_done) begin
            nxt_state = addr_ok ? pot_cmd_pkg::ST_ACK : pot_cmd_pkg::ST_WAIT; // R22 R23
            nxt_after = pot_cmd_pkg::ST_INSTR;
          end
        end
        pot_cmd_pkg::ST_INSTR: begin
          if (byte_done) begin
            nxt_cmd = rx_instr; // R05
            nxt_state = pot_cmd_pkg::ST_ACK; // R22
            nxt_after = pot_cmd_pkg::ST_WAIT;
            nxt_req.sel = rx_instr.sel;
            nxt_req.val[0] = wiper_ff[0];
            nxt_req.val[1] = wiper_ff[1];
            nxt_req.mask = pot_mask(rx_instr.pot);
            unique case (rx_instr.opcode)
              pot_cmd_pkg::OP_READ_WIPER: begin
                nxt_after = pot_cmd_pkg::ST_READ; // R07
                nxt_tx = {2'h0, rx_wiper}; // R25
                if (!sel_zero) nxt_state = pot_cmd_pkg::ST_WAIT; // R07
              end
              pot_cmd_pkg::OP_WRITE_WIPER: begin
                nxt_after = pot_cmd_pkg::ST_DATA; // R08
                if (!sel_zero) nxt_state = pot_cmd_pkg::ST_WAIT;
              end
              pot_cmd_pkg::OP_READ_STORE: begin
                nxt_after = pot_cmd_pkg::ST_READ; // R09
                nxt_tx = {2'h0, rx_store}; // R25
              end
              pot_cmd_pkg::OP_WRITE_STORE: begin
                nxt_after = pot_cmd_pkg::ST_DATA; // R10
              end
              pot_cmd_pkg::OP_STORE_TO_WIPER: begin
                nxt_wiper[rx_instr.pot] = rx_store; // R11
                copy_op = 1'b1; // R11
              end
              pot_cmd_pkg::OP_WIPER_TO_STORE: begin
                nxt_pend = 1'b1; // R12
              end
              pot_cmd_pkg::OP_GLOBAL_RECALL: begin
                if (rx_instr.pot) begin
                  nxt_state = pot_cmd_pkg::ST_WAIT; // R13
                end else begin
                  nxt_wiper[0] = store_ff[idx(1'b0, rx_instr.sel)]; // R13
                  nxt_wiper[1] = store_ff[idx(1'b1, rx_instr.sel)]; // R13
                  copy_op = 1'b1;
                end
              end
              pot_cmd_pkg::OP_GLOBAL_SAVE: begin
                nxt_req.mask = 2'h3; // R14
                nxt_pend = ~rx_instr.pot; // R14
                if (rx_instr.pot) nxt_state = pot_cmd_pkg::ST_WAIT;
              end
              pot_cmd_pkg::OP_STEP: begin
                nxt_after = pot_cmd_pkg::ST_STEP; // R15
                if (!sel_zero) nxt_state = pot_cmd_pkg::ST_WAIT;
              end
              default: begin
                nxt_state = pot_cmd_pkg::ST_WAIT;
              end
            endcase
            if (rx_instr.rsvd) begin
              nxt_state = pot_cmd_pkg::ST_WAIT; // R06
              nxt_pend = 1'b0;
              nxt_wiper = wiper_ff;
              copy_op = 1'b0;
            end
          end
        end
        pot_cmd_pkg::ST_DATA: begin
          if (byte_done) begin
            nxt_state = pot_cmd_pkg::ST_ACK; // R22
            nxt_after = pot_cmd_pkg::ST_WAIT;
            if (cmd_ff.opcode == pot_cmd_pkg::OP_WRITE_WIPER) begin
              nxt_wiper[cmd_ff.pot] = rx_byte[W-1:0]; // R08
            end else begin
              nxt_req.val[cmd_ff.pot] = rx_byte[W-1:0]; // R10
              nxt_pend = 1'b1; // R10
            end
          end
        end
        pot_cmd_pkg::ST_ACK: begin
          if (scl_fall && !ack_on_ff) begin
            nxt_ack_on = 1'b1;
            nxt_oe_n = 1'b0; // R22
          end else if (scl_fall) begin
            nxt_ack_on = 1'b0;
            nxt_state = after_ack_ff;
            nxt_cnt = '0;
            nxt_oe_n = 1'b1;
            if (after_ack_ff == pot_cmd_pkg::ST_READ) begin
              nxt_oe_n = tx_ff[pot_cmd_pkg::BYTE_W-1]; // R25
              nxt_tx = {tx_ff[pot_cmd_pkg::BYTE_W-2:0], 1'b0};
              nxt_cnt = 4'h1;
            end
          end
        end
        pot_cmd_pkg::ST_READ: begin
          if (scl_fall && bit_cnt_ff == pot_cmd_pkg::BYTE_BITS) begin
            nxt_oe_n = 1'b1;
            nxt_state = pot_cmd_pkg::ST_MASTER_ACK;
          end else if (scl_fall) begin
            nxt_oe_n = tx_ff[pot_cmd_pkg::BYTE_W-1]; // R25
            nxt_tx = {tx_ff[pot_cmd_pkg::BYTE_W-2:0], 1'b0};
            nxt_cnt = bit_cnt_ff + 4'h1;
          end
        end
        pot_cmd_pkg::ST_MASTER_ACK: begin
          if (scl_rise) nxt_state = pot_cmd_pkg::ST_WAIT;
        end
        pot_cmd_pkg::ST_STEP: begin
          // Stepping on the clock fall keeps the stop condition from counting as a step.
          if (scl_fall) nxt_wiper[cmd_ff.pot] = step(sel_wiper, sda_prev_ff); // R16 R17 R24
        end
      endcase
    end
  end

  assign nxt_busy_cnt = commit ? BUSY_W'(NV_WRITE_CYCLES) :
                        busy ? busy_cnt_ff - 1'b1 : busy_cnt_ff; // R02 R20

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= pot_cmd_pkg::ST_IDLE;
      after_ack_ff <= pot_cmd_pkg::ST_IDLE;
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      tx_ff <= '0;
      ack_on_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      cmd_ff <= '0;
      nv_pend_ff <= 1'b0;
      nv_req_ff <= '0;
      busy_cnt_ff <= '0;
      nv_busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      after_ack_ff <= nxt_after;
      bit_cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      tx_ff <= nxt_tx;
      ack_on_ff <= nxt_ack_on;
      sda_oe_n_ff <= nxt_oe_n;
      cmd_ff <= nxt_cmd;
      nv_pend_ff <= nxt_pend;
      nv_req_ff <= nxt_req;
      busy_cnt_ff <= nxt_busy_cnt;
      nv_busy_ff <= nxt_busy_cnt != '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < pot_cmd_pkg::NUM_STORES; i++) store_ff[i] <= pot_cmd_pkg::STORE_RESET;
    end else if (commit) begin
      for (int p = 0; p < pot_cmd_pkg::NUM_POTS; p++) begin
        if (nv_req_ff.mask[p]) store_ff[idx(p[0], nv_req_ff.sel)] <= nv_req_ff.val[p]; // R10 R12 R14
      end
    end
  end

  // Recall runs in the first cycle after reset, before any bus traffic.
  always_ff @(posedge clk) begin
    if (reset) begin
      recall_ff <= 1'b1;
      wiper_ff[0] <= pot_cmd_pkg::WIPER_MIN;
      wiper_ff[1] <= pot_cmd_pkg::WIPER_MIN;
    end else begin
      recall_ff <= 1'b0;
      wiper_ff <= nxt_wiper; // R18
    end
  end

  // Switches follow the wiper, but a store copy holds them for the response delay.
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_cnt_ff <= '0;
      switch0_ff <= decode(pot_cmd_pkg::WIPER_MIN);
      switch1_ff <= decode(pot_cmd_pkg::WIPER_MIN);
    end else begin
      if (copy_op) hold_cnt_ff <= HOLD_W'(WIPER_RESP_CYCLES); // R11
      else if (hold_cnt_ff != '0) hold_cnt_ff <= hold_cnt_ff - 1'b1;
      if (!copy_op && hold_cnt_ff == '0) begin
        switch0_ff <= decode(wiper_ff[0]); // R18
        switch1_ff <= decode(wiper_ff[1]); // R18
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence step_up_ev;
    !recall_ff && !busy && !start_det && !stop_det && state_ff == pot_cmd_pkg::ST_STEP &&
      scl_fall && sda_prev_ff;
  endsequence
  sequence step_dn_ev;
    !recall_ff && !busy && !start_det && !stop_det && state_ff == pot_cmd_pkg::ST_STEP &&
      scl_fall && !sda_prev_ff;
  endsequence
  sequence protected_stop;
    !busy && stop_det && !wp_ff;
  endsequence

  AST_BUSY_NO_ACK: assert property (nv_busy_ff |-> sda_oe_n_ff) // R04
    else $error("acknowledge driven during nonvolatile write");
  AST_COMMIT_BUSY: assert property (commit |=> nv_busy_ff [*8]) // R02
    else $error("write cycle did not start after stop");
  AST_BUSY_MAX: assert property (busy_cnt_ff <= pot_cmd_pkg::NV_WRITE_MAX_CYCLES) // R20
    else $error("write cycle longer than the maximum");
  AST_WP_BLOCKS: assert property (protected_stop |=> !nv_busy_ff) // R21
    else $error("write started while protected");
  AST_ADDR_NACK: assert property (!busy && !start_det && !stop_det && !recall_ff && // R23
    state_ff == pot_cmd_pkg::ST_ADDR && byte_done && !addr_ok |=> sda_oe_n_ff [*2])
    else $error("acknowledge for foreign address");
  AST_ACK_DRIVE: assert property (!busy && !start_det && !stop_det && !recall_ff && // R22
    state_ff == pot_cmd_pkg::ST_ACK && scl_fall && !ack_on_ff |=> !sda_oe_n_ff)
    else $error("acknowledge not driven");
  AST_STEP_UP: assert property (step_up_ev ##0 sel_wiper != pot_cmd_pkg::WIPER_MAX // R16
    |=> sel_wiper == $past(sel_wiper) + 6'h01)
    else $error("wiper did not step up");
  AST_STEP_DOWN: assert property (step_dn_ev ##0 sel_wiper != pot_cmd_pkg::WIPER_MIN // R17
    |=> sel_wiper == $past(sel_wiper) - 6'h01)
    else $error("wiper did not step down");
  AST_SATURATE: assert property (step_up_ev ##0 sel_wiper == pot_cmd_pkg::WIPER_MAX // R24
    |=> sel_wiper == pot_cmd_pkg::WIPER_MAX)
    else $error("wiper wrapped past the top");
  AST_FLOOR: assert property (step_dn_ev ##0 sel_wiper == pot_cmd_pkg::WIPER_MIN // R24
    |=> sel_wiper == pot_cmd_pkg::WIPER_MIN)
    else $error("wiper wrapped past the bottom");
  AST_ONE_SWITCH: assert property ($onehot(switch0_ff) && $onehot(switch1_ff)) // R18
    else $error("switch decode not one-hot");
  AST_RECALL: assert property (recall_ff |=> wiper_ff[0] == store_ff[idx(1'b0, 2'h0)] && // R19
    wiper_ff[1] == store_ff[idx(1'b1, 2'h0)])
    else $error("wiper not recalled from store zero");
  AST_COPY_HOLD: assert property (copy_op |=> $stable(switch0_ff) && $stable(switch1_ff)) // R11
    else $error("wiper followed without response delay");
  AST_READ_LEAD: assert property (state_ff == pot_cmd_pkg::ST_ACK && // R25
    after_ack_ff == pot_cmd_pkg::ST_READ |-> tx_ff[7:6] == 2'h0)
    else $error("read byte lacks leading zeros");
endmodule

// ---- pot_bus_master.sv ----
module pot_bus_master (
  input  wire logic clk,
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m_low;
  // The pull-up holds the wire high unless either party pulls it low.
  assign sda = !(m_low || (sda_oe_n === 1'b0 && sda_out === 1'b0));
  initial begin
    scl = 1'b1;
    m_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One serial clock of 8 cycles; the wire is sampled late in the high phase.
  task automatic bit_io(input logic b, output logic s);
    m_low <= !b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    s = sda;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic start();
    m_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(2);
    m_low <= 1'b1;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    m_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    m_low <= 1'b0;
    tick(4);
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rd(input logic master_ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(!master_ack, s);
  endtask
  task automatic poll(input logic [7:0] a, output int tries);
    logic ack;
    tries = 0;
    do begin
      start();
      wr(a, ack);
      stop();
      tries++;
    end while (!ack && tries < 10);
  endtask
endmodule

// ---- dual_pot_command_decoder_tb.sv ----
module dual_pot_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         NVW   = 200;
  localparam logic [3:0] STRAP = 4'h5;
  localparam logic [7:0] ADDR  = {pot_cmd_pkg::DEVICE_TYPE_ID, STRAP};
  logic        clk;
  logic        reset;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe_n;
  logic        nv_busy;
  logic        write_protect_n;
  logic [3:0]  strap_addr;
  logic [63:0] wiper_switch0;
  logic [63:0] wiper_switch1;
  int          n_errors    = 0;
  int          checks_done = 0;
  dual_pot_command_decoder #(.NV_WRITE_CYCLES(NVW), .WIPER_RESP_CYCLES(2)) uut (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .strap_addr(strap_addr), .write_protect_n(write_protect_n),
    .nv_busy(nv_busy), .wiper_switch0(wiper_switch0), .wiper_switch1(wiper_switch1));
  pot_bus_master host (
    .clk(clk), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [63:0] hot(input logic [5:0] v);
    return 64'h1 << v;
  endfunction
  function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] sel, input logic p);
    return {op, sel, 1'b0, p};
  endfunction
  task automatic cmd(input logic [7:0] i, input bit has_d, input logic [7:0] d, input logic ea);
    logic a;
    host.start();
    host.wr(ADDR, a);
    check(a, 1'b1);
    host.wr(i, a);
    check(a, ea);
    if (has_d) begin
      host.wr(d, a);
      check(a, ea);
    end
    host.stop();
    host.tick(8);
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [5:0] exp);
    logic       a;
    logic [7:0] v;
    host.start();
    host.wr(ADDR, a);
    host.wr(i, a);
    host.rd(1'b0, v);
    host.stop();
    check(v, {2'b00, exp});
  endtask
  task automatic nvwait();
    int tries;
    host.tick(3);
    check(nv_busy, 1'b1);
    host.poll(ADDR, tries);
    check(tries > 1 && tries < 10, 1'b1);
  endtask
  task automatic t_wiper();
    cmd(ins(pot_cmd_pkg::OP_WRITE_WIPER, 2'h0, 1'b0), 1, 8'h2a, 1'b1);
    check(wiper_switch0, hot(6'h2a));
    cmd(ins(pot_cmd_pkg::OP_WRITE_WIPER, 2'h0, 1'b1), 1, 8'hcc, 1'b1);
    check(wiper_switch1, hot(6'h0c));
    rdchk(ins(pot_cmd_pkg::OP_READ_WIPER, 2'h0, 1'b0), 6'h2a);
  endtask
  task automatic t_store();
    cmd(ins(pot_cmd_pkg::OP_WRITE_STORE, 2'h2, 1'b1), 1, 8'h17, 1'b1);
    nvwait();
    rdchk(ins(pot_cmd_pkg::OP_READ_STORE, 2'h2, 1'b1), 6'h17);
    cmd(ins(pot_cmd_pkg::OP_STORE_TO_WIPER, 2'h2, 1'b1), 0, 8'h00, 1'b1);
    check(wiper_switch1, hot(6'h17));
  endtask
  task automatic t_save();
    cmd(ins(pot_cmd_pkg::OP_WIPER_TO_STORE, 2'h1, 1'b0), 0, 8'h00, 1'b1);
    nvwait();
    rdchk(ins(pot_cmd_pkg::OP_READ_STORE, 2'h1, 1'b0), 6'h2a);
    cmd(ins(pot_cmd_pkg::OP_GLOBAL_SAVE, 2'h3, 1'b0), 0, 8'h00, 1'b1);
    nvwait();
    cmd(ins(pot_cmd_pkg::OP_WRITE_WIPER, 2'h0, 1'b0), 1, 8'h01, 1'b1);
    cmd(ins(pot_cmd_pkg::OP_WRITE_WIPER, 2'h0, 1'b1), 1, 8'h01, 1'b1);
    cmd(ins(pot_cmd_pkg::OP_GLOBAL_RECALL, 2'h3, 1'b0), 0, 8'h00, 1'b1);
    check(wiper_switch0, hot(6'h2a));
    check(wiper_switch1, hot(6'h17));
  endtask
  task automatic t_step(input logic [5:0] v0, input logic dir, input int n, input logic [5:0] e);
    logic a;
    cmd(ins(pot_cmd_pkg::OP_WRITE_WIPER, 2'h0, 1'b0), 1, {2'b00, v0}, 1'b1);
    host.start();
    host.wr(ADDR, a);
    host.wr(ins(pot_cmd_pkg::OP_STEP, 2'h0, 1'b0), a);
    check(a, 1'b1);
    repeat (n) host.bit_io(dir, a);
    host.stop();
    host.tick(8);
    check(wiper_switch0, hot(e));
  endtask
  task automatic t_refuse();
    logic a;
    host.start();
    host.wr({pot_cmd_pkg::DEVICE_TYPE_ID, ~STRAP}, a);
    check(a, 1'b0);
    host.stop();
    cmd(ins(pot_cmd_pkg::OP_WRITE_WIPER, 2'h0, 1'b0) | 8'h02, 1, 8'h10, 1'b0);
    cmd(ins(pot_cmd_pkg::OP_WRITE_WIPER, 2'h1, 1'b0), 1, 8'h10, 1'b0);
    cmd(ins(pot_cmd_pkg::OP_GLOBAL_RECALL, 2'h3, 1'b1), 0, 8'h00, 1'b0);
    cmd(ins(4'hf, 2'h0, 1'b0), 0, 8'h00, 1'b0);
    check(wiper_switch0, hot(6'h00));
  endtask
  task automatic t_protect();
    write_protect_n <= 1'b0;
    cmd(ins(pot_cmd_pkg::OP_WRITE_STORE, 2'h0, 1'b0), 1, 8'h11, 1'b1);
    check(nv_busy, 1'b0);
    rdchk(ins(pot_cmd_pkg::OP_READ_STORE, 2'h0, 1'b0), 6'h00);
    write_protect_n <= 1'b1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    finish_test();
  end
  initial begin
    reset = 1'b1;
    strap_addr = STRAP;
    write_protect_n = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    host.tick(6);
    check(wiper_switch0, hot(6'h00));
    check(wiper_switch1, hot(6'h00));
    $display("reset test done");
    t_wiper();
    $display("wiper test done");
    t_store();
    $display("store test done");
    t_save();
    $display("save test done");
    t_step(6'h3d, 1'b1, 4, 6'h3f);
    t_step(6'h02, 1'b0, 3, 6'h00);
    $display("step test done");
    t_refuse();
    $display("refuse test done");
    t_protect();
    $display("protect test done");
    finish_test();
  end
endmodule
